// ===== dsg_pkg.sv
// Constants and carrier types for the debug security ID gate.
// Assumes one clock domain; flash ID bytes arrive as a flat vector.
package dsg_pkg;
    // ******************************************
    // ID area layout
    // ******************************************
    localparam int ID_BYTES = 10;
    localparam int BYTE_W = 8;
    localparam logic [23:0] ID_FIRST_ADDR = 24'h00_0070;
    localparam logic [23:0] ID_LAST_ADDR = 24'h00_0079;
    localparam int ENABLE_BYTE = 9;
    localparam int ENABLE_BIT = 7;
    localparam logic [3:0] LAST_INDEX = 4'h9;

    // ******************************************
    // Carrier types
    // ******************************************
    typedef struct packed {
        logic di;            // Interrupts disabled
        logic chan_irq_mask; // Debug channel interrupt masked
        logic standby_noirq; // Standby without maskable release
        logic standby;       // In standby now
        logic use_async;     // Async channel selected, else clocked
        logic main_clk_run;  // Main clock running
        logic async_clk_ok;  // Async clock equals configured clock
    } dsg_cpu_t;

    typedef struct packed {
        logic valid;         // Byte strobe
        logic [7:0] data;    // ID byte, ascending address order
    } dsg_byte_t;

    // States of the comparison
    typedef enum logic [3:0] {
        ST_LOCKED = 4'b0001,
        ST_RECV = 4'b0010,
        ST_OPEN = 4'b0100,
        ST_FAIL = 4'b1000
    } dsg_state_t;
endpackage : dsg_pkg

// ===== dsg_gate.sv
// Debug security ID gate: compares supplied ID, grants debug functions.
// Holds the byte-serial ID compare, the lock state and the function grants.
// Assumes stored ID bytes are stable flash contents; CPU status bits are same-clock.
// Assumes the debug channel delivers one checked byte per strobe.
`timescale 1ns/1ps
`default_nettype none
module dsg_gate
    import dsg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Stored ID area, byte 0 at lowest address
    input wire logic [ID_BYTES*8-1:0] stored_id_i,
    // Supplied ID stream from the debug channel
    input wire logic start_i,
    input wire dsg_byte_t id_byte_i,
    // CPU status
    input wire dsg_cpu_t cpu_i,
    // Debug requests
    input wire logic break_req_i,
    input wire logic mon_req_i,
    input wire logic modify_wr_req_i,
    input wire logic modify_protected_i,
    // Grants and status
    output logic unlocked_o,
    output logic fail_o,
    output logic break_ok_o,
    output logic mon_ok_o,
    output logic modify_wr_ok_o,
    output logic standby_release_o
);
    // ******************************************
    // Reset synchroniser
    // ******************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ******************************************
    // Layout checks
    // ******************************************
    // Index counter and enable byte must fit the ID area
    if (ID_BYTES > 16 || int'(LAST_INDEX) != ID_BYTES - 1
        || ENABLE_BYTE != ID_BYTES - 1) begin : g_bad_layout
        $error("ID area layout does not fit the index counter");
    end

    // ******************************************
    // ID comparison
    // ******************************************
    // Compare state, byte index and running match
    dsg_state_t state;
    logic [3:0] idx;
    logic match_all;
    logic [7:0] stored_byte;
    logic enable_flag;

    // Byte under compare and the enable flag of the stored ID
    assign stored_byte = stored_id_i[idx*BYTE_W +: BYTE_W];
    assign enable_flag = stored_id_i[ENABLE_BYTE*BYTE_W + ENABLE_BIT];

    // Byte-serial compare, ascending address order
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_LOCKED;
            idx <= 4'h0;
            match_all <= 1'b0;
        end else begin
            unique case (state)
                ST_LOCKED, ST_OPEN, ST_FAIL: begin
                    if (start_i) begin
                        state <= ST_RECV;
                        idx <= 4'h0;
                        match_all <= 1'b1;
                    end
                end
                ST_RECV: begin
                    if (id_byte_i.valid) begin
                        idx <= idx + 4'h1;
                        if (idx == LAST_INDEX) begin
                            // Open only on full match and flag set
                            if (match_all && (id_byte_i.data == stored_byte) && enable_flag)
                                state <= ST_OPEN;
                            else
                                state <= ST_FAIL;
                        end else if (id_byte_i.data != stored_byte) begin
                            match_all <= 1'b0;
                        end
                    end
                end
                default: state <= ST_LOCKED;
            endcase
        end
    end

    // ******************************************
    // Function gating
    // ******************************************
    logic break_block;
    logic mon_block;
    // Forced-break blocking conditions
    assign break_block = cpu_i.di | cpu_i.chan_irq_mask | cpu_i.standby_noirq
        | (cpu_i.use_async & ~cpu_i.main_clk_run);
    // Monitor and modify add the wrong async clock case
    assign mon_block = break_block | (cpu_i.use_async & ~cpu_i.async_clk_ok);

    // Gate open: full match with the enable flag set
    logic open;
    assign open = (state == ST_OPEN);

    // Lock status follows the compare state
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            unlocked_o <= 1'b0;
            fail_o <= 1'b0;
        end else begin
            unlocked_o <= open;
            fail_o <= (state == ST_FAIL);
        end
    end

    // Break, monitor and modify grants, one cycle per request cycle
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            break_ok_o <= 1'b0;
            mon_ok_o <= 1'b0;
            modify_wr_ok_o <= 1'b0;
        end else begin
            break_ok_o <= open & break_req_i & ~break_block;
            mon_ok_o <= open & mon_req_i & ~mon_block;
            modify_wr_ok_o <= open & modify_wr_req_i & ~mon_block
                & ~modify_protected_i;
        end
    end

    // Standby exit by a monitor or modify access
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_release_o <= 1'b0;
        end else begin
            standby_release_o <= open & cpu_i.standby & (mon_req_i | modify_wr_req_i)
                & ~mon_block & (~cpu_i.use_async | cpu_i.main_clk_run);
        end
    end

    // ******************************************
    // Assertions
    // ******************************************
    // No unlock, break or monitor grant unless the gate was open one cycle earlier
    a_locked_grants: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !$past(open) |-> !unlocked_o && !break_ok_o && !mon_ok_o)
        else $error("grant without unlock");
    // Clear enable flag ends the entry in failure
    a_flag_refuses: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state == ST_RECV && id_byte_i.valid && idx == LAST_INDEX && !enable_flag)
        |=> state == ST_FAIL)
        else $error("open with enable flag clear");
    // Any earlier byte mismatch ends the entry in failure
    a_open_needs_match: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state == ST_RECV && id_byte_i.valid && idx == LAST_INDEX && !match_all)
        |=> state == ST_FAIL)
        else $error("open after mismatch");
    // Blocking conditions hold the break grant low
    a_break_blocked: assert property (@(posedge mclk_i) disable iff (!rst_n)
        break_block |=> !break_ok_o)
        else $error("break honoured while blocked");
    // Wrong async clock stops monitor and modify
    a_mon_blocked: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (cpu_i.use_async && !cpu_i.async_clk_ok) |=> !mon_ok_o && !modify_wr_ok_o)
        else $error("monitor with wrong clock");
    // Protected-sequence targets never see a modify write
    a_protected_write: assert property (@(posedge mclk_i) disable iff (!rst_n)
        modify_protected_i |=> !modify_wr_ok_o)
        else $error("protected register written");
    // Unblocked monitor access in standby releases it
    a_standby_release: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (open && cpu_i.standby && mon_req_i && !mon_block) |=> standby_release_o)
        else $error("standby not released");
    // Async channel with stopped clock never releases standby
    a_release_clock: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (cpu_i.use_async && !cpu_i.main_clk_run) |=> !standby_release_o)
        else $error("standby released with clock stopped");
    // Open gate shows unlocked one edge later
    a_unlock_follows: assert property (@(posedge mclk_i) disable iff (!rst_n)
        open |=> unlocked_o)
        else $error("unlock missing");
    // Unlock only after a last byte seen with the flag set
    a_flag_at_unlock: assert property (@(posedge mclk_i) disable iff (!rst_n)
        $rose(unlocked_o) |-> $past(enable_flag, 2))
        else $error("unlock with enable flag clear");
    // Failed entry shows fail and keeps the lock
    a_fail_follows: assert property (@(posedge mclk_i) disable iff (!rst_n)
        state == ST_FAIL |=> fail_o && !unlocked_o)
        else $error("fail status missing");
    // A new entry drops the unlock two edges after start
    a_restart_relocks: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state != ST_RECV && start_i) |=> state == ST_RECV ##1 !unlocked_o)
        else $error("gate stays open after restart");
    // Grants answer only a request of the cycle before
    a_break_needs_req: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !break_req_i |=> !break_ok_o)
        else $error("break granted without request");
    a_mon_needs_req: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !mon_req_i |=> !mon_ok_o)
        else $error("monitor granted without request");
    a_modify_needs_req: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !modify_wr_req_i |=> !modify_wr_ok_o)
        else $error("modify granted without request");

    // Main scenarios: unlock, failed entry, break, standby exit, re-entry
    c_unlock: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(unlocked_o));
    c_fail: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(fail_o));
    c_break: cover property (@(posedge mclk_i) disable iff (!rst_n) break_ok_o);
    c_release: cover property (@(posedge mclk_i) disable iff (!rst_n) standby_release_o);
    c_restart: cover property (@(posedge mclk_i) disable iff (!rst_n) open && start_i);
endmodule : dsg_gate
`default_nettype wire

// ===== dsg_dbg_model.sv
// Emulator model: sends a supplied ID to the gate as a byte stream.
// Assumes the bench calls send() from a process synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module dsg_dbg_model
    import dsg_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // ID stream
    output logic start_o,
    output var dsg_byte_t id_byte_o
);
    // User-program mode setup: select bit cleared while the pin is low
    logic debug_reset_pin;
    logic debug_mode_select_bit;
    logic mode_ready;
    assign mode_ready = !debug_mode_select_bit && debug_reset_pin;
    // Idle lines at power-up, then mode setup
    initial begin
        start_o = 1'b0;
        id_byte_o = '0;
        debug_reset_pin = 1'b0;
        debug_mode_select_bit = 1'b1;
        @(negedge mclk_i) debug_mode_select_bit = 1'b0;
        @(negedge mclk_i) debug_reset_pin = 1'b1;
    end
    // Hex text to ID bytes; first character pair is the lowest address
    function automatic logic [ID_BYTES*8-1:0] hex_to_code(input string text);
        byte ch;
        logic [3:0] nib;
        logic [ID_BYTES*8-1:0] code;
        code = '0;
        for (int c = 0; c < 2 * ID_BYTES; c++) begin
            ch = text[c];
            if (ch >= "a") begin
                ch = ch - 8'h20;
            end
            nib = (ch >= "A") ? 4'(ch - "A" + 10) : 4'(ch - "0");
            code[8 * (c / 2) + 4 * (1 - c % 2) +: 4] = nib;
        end
        return code;
    endfunction : hex_to_code
    // Start pulse, then bytes lowest address first; idle data inverted
    task automatic send(input logic [ID_BYTES*8-1:0] code, input int gap);
        wait (mode_ready === 1'b1);
        @(negedge mclk_i) start_o = 1'b1;
        for (int k = 0; k < ID_BYTES; k++) begin
            @(negedge mclk_i) start_o = 1'b0;
            id_byte_o = {1'b1, code[8*k +: 8]};
            repeat (gap) @(negedge mclk_i) id_byte_o = {1'b0, ~id_byte_o.data};
        end
        @(negedge mclk_i) id_byte_o = {1'b0, ~id_byte_o.data};
    endtask : send
endmodule : dsg_dbg_model
`default_nettype wire

// ===== tb_top.sv
// Testbench for the debug security ID gate.
// Assumes the emulator model feeds the ID; all other inputs driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dsg_pkg::*;
();
    // ****
    // Signals
    // ****
    localparam logic [79:0] ID_REF = 80'hD423_F1DE_BC9A_7856_3412;
    logic mclk_i = 1'b0;
    logic reset_n_i, brk, mon, mod, prot, unl, fl, bok, mok, wok, sbr, start;
    logic [79:0] stored, typed;
    dsg_cpu_t cpu;
    dsg_byte_t idb;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    always #2 mclk_i = ~mclk_i;
    dsg_dbg_model model (.mclk_i(mclk_i), .start_o(start), .id_byte_o(idb));
    dsg_gate uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .stored_id_i(stored),
        .start_i(start), .id_byte_i(idb), .cpu_i(cpu), .break_req_i(brk),
        .mon_req_i(mon), .modify_wr_req_i(mod), .modify_protected_i(prot),
        .unlocked_o(unl), .fail_o(fl), .break_ok_o(bok), .mon_ok_o(mok),
        .modify_wr_ok_o(wok), .standby_release_o(sbr));
    // ****
    // Checking and closing
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // Hang guard
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // Grants {break, monitor, modify, standby release} for {prot, cpu}
    function automatic logic [7:0] exp_grants(input logic [7:0] v, input logic open);
        logic bb, mb;
        bb = v[6] | v[5] | v[4] | (v[2] & ~v[1]);
        mb = bb | (v[2] & ~v[0]);
        exp_grants = {4'h0, open & ~bb, open & ~mb, open & ~mb & ~v[7], open & ~mb & v[3]};
    endfunction : exp_grants
    // ****
    // Tests
    // ****
    task automatic sweep(input logic open);
        for (int i = 0; i < 256; i++) begin
            @(negedge mclk_i) {prot, cpu} = i[7:0];
            repeat (2) @(negedge mclk_i);
            chk({4'h0, bok, mok, wok, sbr}, exp_grants(i[7:0], open));
        end
        $display("sweep done at %0t", $time);
    endtask : sweep
    task automatic entry(input logic [79:0] code, input int gap, input logic [7:0] exp);
        model.send(code, gap);
        repeat (2) @(negedge mclk_i);
        chk({6'h0, unl, fl}, exp);
        $display("entry done at %0t", $time);
    endtask : entry
    initial begin
        reset_n_i = 1'b0;
        stored = ID_REF;
        cpu = '0;
        {brk, mon, mod, prot} = 4'h0;
        repeat (20) @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge mclk_i) {brk, mon, mod} = 3'h7;
        sweep(1'b0);
        entry(ID_REF, 0, 8'h02);
        sweep(1'b1);
        entry(ID_REF ^ 80'h1, 2, 8'h01);
        sweep(1'b0);
        entry(ID_REF ^ (80'h1 << 72), 0, 8'h01);
        typed = model.hex_to_code("123456789abcDEF123d4");
        for (int k = 0; k < ID_BYTES; k++) begin
            chk(typed[8*k +: 8], ID_REF[8*k +: 8]);
        end
        entry(typed, 1, 8'h02);
        // Requests off, then on, nothing blocked and standby set
        @(negedge mclk_i) {brk, mon, mod, prot, cpu} = 11'h008;
        repeat (2) @(negedge mclk_i);
        chk({4'h0, bok, mok, wok, sbr}, 8'h00);
        @(negedge mclk_i) {brk, mon, mod} = 3'h7;
        repeat (2) @(negedge mclk_i);
        chk({4'h0, bok, mok, wok, sbr}, exp_grants(8'h08, 1'b1));
        $display("grant test done at %0t", $time);
        // Mid-run reset relocks an open gate
        @(negedge mclk_i) reset_n_i = 1'b0;
        @(negedge mclk_i) reset_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        chk({4'h0, unl, bok, mok, sbr}, 8'h00);
        $display("reset test done at %0t", $time);
        @(negedge mclk_i) stored = ID_REF & ~(80'h1 << 79);
        entry(stored, 0, 8'h01);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
